/* File: rtl/rscc_pkg.sv */
/*
  Shared constants, carriers and helpers for the ring/step counter with
  its comparison units.
  Assumes a single module clock and synchronous active-low reset.
*/
`default_nettype none
package rscc_pkg;
  localparam int          RSCC_CH        = 2;
  localparam logic [31:0] RSCC_MASK16    = 32'h0000FFFF;
  localparam logic [31:0] RSCC_TALLY_RST = 32'h00000000;
  localparam logic [31:0] RSCC_ONE       = 32'h00000001;
  localparam logic [32:0] RSCC_MOD32     = 33'h100000000;
  localparam logic [32:0] RSCC_MOD16     = 33'h000010000;

  typedef enum logic [2:0] {
    RSCC_CMP_NONE = 3'h0,
    RSCC_CMP_EQ   = 3'h1,
    RSCC_CMP_NE   = 3'h2,
    RSCC_CMP_GT   = 3'h3,
    RSCC_CMP_LT   = 3'h4,
    RSCC_CMP_GE   = 3'h5,
    RSCC_CMP_LE   = 3'h6
  } rscc_cmode_t;

  typedef struct packed {
    logic        span_mode;
    rscc_cmode_t mode_a;
    rscc_cmode_t mode_b;
    logic [31:0] val_a;
    logic [31:0] val_b;
  } rscc_cmp_cfg_t;

  typedef struct packed {
    logic          count_en;
    logic          ring;
    logic          add_mode;
    logic [31:0]   floor_b;
    logic [31:0]   ceil_b;
    logic [31:0]   step;
    logic [31:0]   reload;
    rscc_cmp_cfg_t cmp;
  } rscc_cfg_t;

  typedef struct packed {
    logic up;
    logic down;
    logic run;
    logic stop;
    logic preset;
  } rscc_evt_t;

  typedef struct packed {
    logic [1:0][31:0] tally;
    logic [1:0]       timing;
    logic [1:0]       ovf;
    logic [1:0]       unf;
  } rscc_state_t;

  typedef struct packed {
    logic a;
    logic b;
  } rscc_cmp_st_t;

  // keep only the bits of the counter's width
  function automatic logic [31:0] rscc_fit(input logic [31:0] v, input logic w32);
    rscc_fit = w32 ? v : (v & RSCC_MASK16);
  endfunction

  // tally in its own format, widened so signed and unsigned compare alike
  function automatic logic signed [33:0] rscc_ext(input logic [31:0] v,
                                                  input logic w32, input logic sgn);
    if (w32) rscc_ext = sgn ? {{2{v[31]}}, v} : {2'b00, v};
    else     rscc_ext = sgn ? {{18{v[15]}}, v[15:0]} : {18'h0, v[15:0]};
  endfunction
endpackage
`default_nettype wire

/* File: rtl/rscc_step.sv */
/*
  Next-tally arithmetic for one counter timer: ring wrap and linear limits,
  with a unit or programmed step.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module rscc_step (
  input  wire logic [31:0] tally,
  input  wire logic [31:0] floor_b,
  input  wire logic [31:0] ceil_b,
  input  wire logic [31:0] step,
  input  wire logic        ring,
  input  wire logic        w32,
  input  wire logic        sgn,
  input  wire logic        up,
  output logic      [31:0] next_tally,
  output logic             ovf,
  output logic             unf
);
  import rscc_pkg::*;
  logic        [32:0] off;
  logic        [32:0] span;
  logic        [32:0] stp;
  logic        [32:0] sum;
  logic signed [33:0] et;
  logic signed [33:0] ef;
  logic signed [33:0] ec;
  logic signed [33:0] es;

  always_comb begin
    off  = {1'b0, rscc_fit(tally - floor_b, w32)};
    span = {1'b0, rscc_fit(ceil_b - floor_b, w32)};
    stp  = {1'b0, rscc_fit(step, w32)};
    et   = rscc_ext(tally, w32, sgn);
    ef   = rscc_ext(floor_b, w32, sgn);
    ec   = rscc_ext(ceil_b, w32, sgn);
    es   = {2'b00, rscc_fit(step, w32)};
    sum  = off;
    ovf  = 1'b0;
    unf  = 1'b0;
    next_tally = tally;
    // equal bounds give the whole numeric range
    if (span == 33'h0) begin
      span = w32 ? RSCC_MOD32 : RSCC_MOD16;
    end
    if (ring) begin
      // offsets from the floor make both bound orders one case
      if (up) begin
        sum = off + stp;
        if (sum >= span) begin
          sum = sum - span;
        end
      end else if (off < stp) begin
        sum = off + span - stp;
      end else begin
        sum = off - stp;
      end
      next_tally = rscc_fit(floor_b + sum[31:0], w32);
    end else if (up) begin
      if (ec <= ef || et + es > ec) ovf = 1'b1;
      else next_tally = rscc_fit(tally + step, w32);
    end else begin
      if (ec <= ef || et - es < ef) unf = 1'b1;
      else next_tally = rscc_fit(tally - step, w32);
    end
  end
endmodule // rscc_step
`default_nettype wire

/* File: rtl/rscc_cmp.sv */
/*
  One comparison unit: two conditions against one counter timer's tally,
  either two single comparisons or an in-range / out-of-range pair.
  The value given is the tally being loaded on this edge.
*/
`timescale 1ns/1ps
`default_nettype none
module rscc_cmp (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic [31:0]            value,
  input  wire logic                   w32,
  input  wire logic                   sgn,
  input  wire rscc_pkg::rscc_cmp_cfg_t cfg,
  output logic                        out_a,
  output logic                        out_b
);
  import rscc_pkg::*;
  rscc_cmp_st_t       st;
  rscc_cmp_st_t       next_st;
  logic signed [33:0] ev;
  logic signed [33:0] ea;
  logic signed [33:0] eb;

  function automatic logic test(input rscc_cmode_t m, input logic signed [33:0] x,
                                input logic signed [33:0] y);
    unique case (m)
      RSCC_CMP_NONE: test = 1'b0;
      RSCC_CMP_EQ:   test = x == y;
      RSCC_CMP_NE:   test = x != y;
      RSCC_CMP_GT:   test = x > y;
      RSCC_CMP_LT:   test = x < y;
      RSCC_CMP_GE:   test = x >= y;
      RSCC_CMP_LE:   test = x <= y;
      default:       test = 1'b0;
    endcase
  endfunction

  always_comb begin
    ev = rscc_ext(value, w32, sgn);
    ea = rscc_ext(cfg.val_a, w32, sgn);
    eb = rscc_ext(cfg.val_b, w32, sgn);
    if (cfg.span_mode) begin
      next_st.a = (ea <= ev) && (ev <= eb);
      next_st.b = !((ea <= ev) && (ev <= eb));
    end else begin
      next_st.a = test(cfg.mode_a, ev, ea);
      next_st.b = test(cfg.mode_b, ev, eb);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) st <= '0;
    else       st <= next_st;
  end

  assign out_a = st.a;
  assign out_b = st.b;

  a_cmp_equal_high : assert property (@(posedge sys_clk) disable iff (!nrst)
    (!cfg.span_mode && cfg.mode_a == RSCC_CMP_EQ && ev == ea) |=> out_a)
    else $error("compare output low on a match");
endmodule // rscc_cmp
`default_nettype wire

/* File: rtl/rscc_top.sv */
/*
  Counter unit: two 16-bit counter timers, or one 32-bit counter timer,
  each with ring/linear counting, an optional step and a fixed comparison
  unit on its tally.
  Assumes up/down pulses and run/stop/preset events arrive as one-cycle
  highs synchronous to sys_clk from the event logic beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module rscc_top (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         logic_run,
  input  wire logic                         wide32,
  input  wire logic                         signed_fmt,
  input  wire rscc_pkg::rscc_cfg_t [1:0]    cfg,
  input  wire rscc_pkg::rscc_evt_t [1:0]    evt,
  output logic                     [1:0][31:0] tally,
  output logic                     [1:0]    ovf,
  output logic                     [1:0]    unf,
  output logic                     [1:0]    cmp_a,
  output logic                     [1:0]    cmp_b
);
  import rscc_pkg::*;

  // **************************************************
  // state and per-channel decode
  // **************************************************
  rscc_state_t      st;
  rscc_state_t      next_st;
  logic [1:0]       active;
  logic [1:0]       go_up;
  logic [1:0]       go_dn;
  logic [1:0][31:0] step_amt;
  logic [1:0][31:0] step_nxt;
  logic [1:0]       step_ovf;
  logic [1:0]       step_unf;

  always_comb begin
    for (int i = 0; i < RSCC_CH; i++) begin
      // channel 1 only exists as a 16-bit counter
      active[i]   = (i == 0) || !wide32;
      step_amt[i] = cfg[i].add_mode ? cfg[i].step : RSCC_ONE;
      // stop outranks the pulses; errors freeze the count
      go_up[i] = active[i] && logic_run && cfg[i].count_en && !evt[i].stop
                 && !evt[i].preset && !st.ovf[i] && !st.unf[i]
                 && (evt[i].up || st.timing[i]);
      go_dn[i] = active[i] && logic_run && cfg[i].count_en && !evt[i].stop
                 && !evt[i].preset && !st.ovf[i] && !st.unf[i]
                 && evt[i].down && !go_up[i];
    end
  end

  // **************************************************
  // step arithmetic and comparison units
  // **************************************************
  for (genvar gi = 0; gi < RSCC_CH; gi++) begin : g_ch
    rscc_step u_step (
      .tally      (st.tally[gi]),
      .floor_b    (cfg[gi].floor_b),
      .ceil_b     (cfg[gi].ceil_b),
      .step       (step_amt[gi]),
      .ring       (cfg[gi].ring),
      .w32        (wide32),
      .sgn        (signed_fmt),
      .up         (go_up[gi]),
      .next_tally (step_nxt[gi]),
      .ovf        (step_ovf[gi]),
      .unf        (step_unf[gi])
    );

    // hard-wired counter-to-comparator link
    rscc_cmp u_cmp (
      .sys_clk (sys_clk),
      .nrst    (nrst && active[gi]), // second comparator held clear in 32-bit mode
      .value   (next_st.tally[gi]),
      .w32     (wide32),
      .sgn     (signed_fmt),
      .cfg     (cfg[gi].cmp),
      .out_a   (cmp_a[gi]),
      .out_b   (cmp_b[gi])
    );
  end

  // **************************************************
  // tally update
  // **************************************************
  always_comb begin
    next_st = st;
    for (int i = 0; i < RSCC_CH; i++) begin
      // run/stop timing gate, stop wins
      if (evt[i].stop)     next_st.timing[i] = 1'b0;
      else if (evt[i].run) next_st.timing[i] = 1'b1;
      if (!logic_run || !active[i]) begin
        next_st.tally[i]  = RSCC_TALLY_RST;
        next_st.timing[i] = 1'b0;
        next_st.ovf[i]    = 1'b0;
        next_st.unf[i]    = 1'b0;
      end else if (evt[i].preset) begin
        next_st.tally[i] = rscc_fit(cfg[i].reload, wide32);
        next_st.ovf[i]   = 1'b0;
        next_st.unf[i]   = 1'b0;
      end else if (go_up[i] || go_dn[i]) begin
        // one step per cycle at most
        if (step_ovf[i])      next_st.ovf[i] = 1'b1;
        else if (step_unf[i]) next_st.unf[i] = 1'b1;
        else                  next_st.tally[i] = step_nxt[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) st <= '0;
    else       st <= next_st;
  end

  assign tally = st.tally;
  assign ovf   = st.ovf;
  assign unf   = st.unf;

  // **************************************************
  // checks on channel 0, then on channel 1
  // **************************************************
  logic lo_lt_hi;
  logic lo_eq_hi;
  logic hi_lt_lo;
  logic plain_ring;
  logic signed [33:0] lin_sum;
  logic signed [33:0] lin_top;
  logic        [31:0] wrap_val;
  logic               ring_over;
  logic               nar_fit;
  logic               ch1_fits;

  assign lo_lt_hi   = cfg[0].floor_b < cfg[0].ceil_b;
  assign lo_eq_hi   = cfg[0].floor_b == cfg[0].ceil_b;
  assign hi_lt_lo   = cfg[0].ceil_b < cfg[0].floor_b;
  assign plain_ring = cfg[0].ring && !cfg[0].add_mode;
  assign lin_sum    = rscc_ext(st.tally[0], wide32, signed_fmt)
                      + {2'b00, cfg[0].step};
  assign lin_top    = rscc_ext(cfg[0].ceil_b, wide32, signed_fmt);
  // expected ring value after a step that passes the ceiling
  assign wrap_val   = cfg[0].floor_b + (cfg[0].step - (cfg[0].ceil_b - st.tally[0]));
  assign ring_over  = {1'b0, st.tally[0]} + {1'b0, cfg[0].step} >= {1'b0, cfg[0].ceil_b};
  assign nar_fit    = wide32 || cfg[0].ceil_b <= RSCC_MASK16;
  assign ch1_fits   = cfg[1].floor_b <= RSCC_MASK16;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_ring_no_error : assert property (
    (cfg[0].ring && logic_run && !evt[0].preset && !ovf[0] && !unf[0])
    |=> (!ovf[0] && !unf[0]))
    else $error("ring mode raised an error flag");

  a_ring_up_wrap : assert property (
    (wide32 && !signed_fmt && plain_ring && lo_lt_hi && go_up[0]
     && tally[0] == cfg[0].ceil_b - RSCC_ONE)
    |=> tally[0] == $past(cfg[0].floor_b))
    else $error("up count at ceiling did not load floor");

  a_ring_down_wrap : assert property (
    (wide32 && !signed_fmt && plain_ring && lo_lt_hi && go_dn[0]
     && tally[0] == cfg[0].floor_b)
    |=> tally[0] == $past(cfg[0].ceil_b) - RSCC_ONE)
    else $error("down count at floor did not load ceiling minus one");

  a_ring_no_ceil : assert property (
    (wide32 && !signed_fmt && plain_ring && lo_lt_hi
     && (go_up[0] || go_dn[0])
     && tally[0] >= cfg[0].floor_b && tally[0] < cfg[0].ceil_b)
    |=> tally[0] != $past(cfg[0].ceil_b))
    else $error("ring counting stored the ceiling");

  a_full_wrap : assert property (
    (wide32 && signed_fmt && plain_ring && lo_eq_hi && go_up[0]
     && tally[0] == 32'h7FFFFFFF)
    |=> tally[0] == 32'h80000000)
    else $error("signed full range did not wrap to minimum");

  a_inverted_wrap : assert property (
    (wide32 && !signed_fmt && plain_ring && hi_lt_lo && go_dn[0]
     && tally[0] == cfg[0].floor_b)
    |=> tally[0] == $past(cfg[0].ceil_b) - RSCC_ONE)
    else $error("inverted bounds down wrap wrong");

  a_narrow_wrap : assert property (
    (!wide32 && !signed_fmt && plain_ring && lo_eq_hi && go_dn[0]
     && tally[0] == 32'h00000000)
    |=> tally[0] == 32'h0000FFFF)
    else $error("16-bit down from zero did not give 65535");

  a_step_add : assert property (
    (wide32 && cfg[0].ring && cfg[0].add_mode && lo_eq_hi && go_up[0])
    |=> tally[0] == $past(tally[0]) + $past(cfg[0].step))
    else $error("step not added to the tally");

  a_linear_hold : assert property (
    (wide32 && !cfg[0].ring && cfg[0].add_mode && go_up[0]
     && lin_sum > lin_top)
    |=> ($stable(tally[0]) && ovf[0]) ##1 (ovf[0] || $past(evt[0].preset)
        || !$past(logic_run)))
    else $error("linear step overrun did not hold and flag");

  a_preset_load : assert property (
    (wide32 && logic_run && evt[0].preset)
    |=> (tally[0] == $past(cfg[0].reload) && !ovf[0] && !unf[0]))
    else $error("preset did not load reload value");

  a_stop_clear : assert property (
    !logic_run |=> (tally[0] == RSCC_TALLY_RST && tally[1] == RSCC_TALLY_RST))
    else $error("tally not cleared by logic stop");

  a_gate_hold : assert property (
    (logic_run && !cfg[0].count_en && !evt[0].preset) |=> $stable(tally[0]))
    else $error("tally moved with count gate off");

  a_up_wins : assert property (
    (wide32 && plain_ring && lo_eq_hi && go_up[0] && evt[0].down)
    |=> tally[0] == $past(tally[0]) + RSCC_ONE)
    else $error("simultaneous up and down did not count up");

  a_ring_step_wrap : assert property (
    (!signed_fmt && nar_fit && cfg[0].ring && cfg[0].add_mode && lo_lt_hi && go_up[0]
     && tally[0] >= cfg[0].floor_b && tally[0] < cfg[0].ceil_b && ring_over
     && cfg[0].step < cfg[0].ceil_b - cfg[0].floor_b)
    |=> tally[0] == $past(wrap_val))
    else $error("ring step overrun did not wrap from the floor");

  a_one_step : assert property (
    (wide32 && plain_ring && lo_eq_hi && (go_up[0] || go_dn[0]))
    |=> (tally[0] == $past(tally[0]) + RSCC_ONE || tally[0] == $past(tally[0]) - RSCC_ONE))
    else $error("more than one count step in a cycle");

  a_stop_hold : assert property (
    (logic_run && evt[0].stop && !evt[0].preset) |=> $stable(tally[0]))
    else $error("tally moved on a stop event");

  a_ch1_idle : assert property (
    wide32 |=> (tally[1] == RSCC_TALLY_RST && !ovf[1] && !unf[1] && !cmp_a[1] && !cmp_b[1]))
    else $error("second channel active in 32-bit mode");

  a_ch1_narrow : assert property (
    (!wide32 && !signed_fmt && cfg[1].ring && !cfg[1].add_mode
     && cfg[1].floor_b == cfg[1].ceil_b && go_dn[1] && tally[1] == 32'h00000000)
    |=> tally[1] == 32'h0000FFFF)
    else $error("second channel down from zero did not give 65535");

  a_ch1_crossed : assert property (
    (!wide32 && !signed_fmt && cfg[1].ring && !cfg[1].add_mode && ch1_fits
     && cfg[1].ceil_b < cfg[1].floor_b && go_up[1] && tally[1] == cfg[1].ceil_b - RSCC_ONE)
    |=> tally[1] == $past(cfg[1].floor_b))
    else $error("second channel inverted bounds up wrap wrong");
endmodule // rscc_top
`default_nettype wire

/* File: test/rscc_evt_src.sv */
/*
  Event source beside the counter unit: one-cycle up, down, run, stop and
  preset pulses per channel, as the event detection logic gives them.
  Assumes sys_clk and nrst are those of the counter unit.
*/
`timescale 1ns/1ps
`default_nettype none
module rscc_evt_src (
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  output var  rscc_pkg::rscc_evt_t [1:0] evt
);
  import rscc_pkg::*;

  initial evt = '0;

  // one pulse of one cycle, launched just after an edge, never in reset
  task automatic fire(input rscc_evt_t [1:0] e);
    while (nrst !== 1'b1) @(posedge sys_clk);
    @(posedge sys_clk);
    #1 evt = e;
    @(posedge sys_clk);
    #1 evt = '0;
  endtask
endmodule // rscc_evt_src
`default_nettype wire

/* File: test/testbench.sv */
/*
  Self-checking bench for the ring/step counter unit and its comparators.
  Assumes the event source model drives the event pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rscc_pkg::*;
  localparam logic [4:0] E_UP   = 5'h10;
  localparam logic [4:0] E_DN   = 5'h08;
  localparam logic [4:0] E_RUN  = 5'h04;
  localparam logic [4:0] E_STOP = 5'h02;
  localparam logic [4:0] E_PRE  = 5'h01;
  logic             sys_clk;
  logic             nrst;
  logic             logic_run;
  logic             wide32;
  logic             signed_fmt;
  rscc_cfg_t [1:0]  cfg;
  rscc_evt_t [1:0]  evt;
  logic [1:0][31:0] tally;
  logic [1:0]       ovf;
  logic [1:0]       unf;
  logic [1:0]       cmp_a;
  logic [1:0]       cmp_b;
  logic [31:0]      prev;
  logic [6:0]       tbl;
  int               n_mismatch;
  int               cmp_count;

  rscc_top u_rscc_top (
    .sys_clk(sys_clk), .nrst(nrst), .logic_run(logic_run), .wide32(wide32),
    .signed_fmt(signed_fmt), .cfg(cfg), .evt(evt), .tally(tally), .ovf(ovf),
    .unf(unf), .cmp_a(cmp_a), .cmp_b(cmp_b)
  );
  rscc_evt_src u_rscc_evt_src (.sys_clk(sys_clk), .nrst(nrst), .evt(evt));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic setc(input int ch, input logic rg, input logic ad, input logic [31:0] fl,
                      input logic [31:0] ce, input logic [31:0] st, input logic [31:0] rl);
    cfg[ch].count_en = 1'b1;
    cfg[ch].ring = rg;
    cfg[ch].add_mode = ad;
    cfg[ch].floor_b = fl;
    cfg[ch].ceil_b = ce;
    cfg[ch].step = st;
    cfg[ch].reload = rl;
  endtask

  // one event on one channel, then the tally just loaded
  task automatic op(input int ch, input logic [4:0] k, input logic [31:0] exp);
    u_rscc_evt_src.fire(ch == 1 ? {k, 5'h00} : {5'h00, k});
    chk(tally[ch], exp);
  endtask

  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    nrst = 1'b0;
    logic_run = 1'b0;
    wide32 = 1'b0;
    signed_fmt = 1'b0;
    cfg = '0;
    repeat (4) @(posedge sys_clk);
    #1 nrst = 1'b1;
    logic_run = 1'b1;
    chk(tally[0], 32'h0);
    // 16-bit unsigned ring, floor below ceiling; equal and crossed bounds on channel 1
    setc(0, 1'b1, 1'b0, 32'h0, 32'h7D0, 32'h0, 32'h7CE);
    op(0, E_PRE, 32'h7CE);
    op(0, E_UP, 32'h7CF);
    op(0, E_UP | E_DN, 32'h0);
    op(0, E_UP, 32'h1);
    op(0, E_DN, 32'h0);
    op(0, E_DN, 32'h7CF);
    chk({30'h0, ovf[0], unf[0]}, 32'h0);
    setc(1, 1'b1, 1'b0, 32'h5, 32'h5, 32'h0, 32'h0);
    op(1, E_PRE, 32'h0);
    op(1, E_DN, 32'hFFFF);
    op(1, E_UP, 32'h0);
    setc(1, 1'b1, 1'b0, 32'h64, 32'h32, 32'h0, 32'h31);
    op(1, E_PRE, 32'h31);
    op(1, E_UP, 32'h64);
    op(1, E_DN, 32'h31);
    // ring with a step of 5 below the span of 1000
    setc(0, 1'b1, 1'b1, 32'h0, 32'h3E8, 32'h5, 32'h3E6);
    op(0, E_PRE, 32'h3E6);
    op(0, E_UP, 32'h3);
    op(0, E_UP, 32'h8);
    op(0, E_DN, 32'h3);
    cfg[0].reload = 32'h0;
    op(0, E_PRE, 32'h0);
    op(0, E_RUN, 32'h0);
    for (int i = 0; i < 3; i++) begin
      prev = tally[0];
      @(posedge sys_clk);
      #1 chk(tally[0], prev + 32'h5);
    end
    u_rscc_evt_src.fire({5'h00, E_STOP});
    prev = tally[0];
    repeat (2) @(posedge sys_clk);
    #1 chk(tally[0], prev);
    cfg[0].count_en = 1'b0;
    op(0, E_UP, prev);
    // comparators, 16-bit signed
    signed_fmt = 1'b1;
    setc(0, 1'b1, 1'b0, 32'h0, 32'h0, 32'h0, 32'h3);
    cfg[0].cmp = '{span_mode: 1'b0, mode_a: RSCC_CMP_EQ, mode_b: RSCC_CMP_LT,
                   val_a: 32'h3, val_b: 32'h0};
    op(0, E_PRE, 32'h3);
    chk({30'h0, cmp_a[0], cmp_b[0]}, 32'h2);
    cfg[0].reload = 32'hFFFF;
    op(0, E_PRE, 32'hFFFF);
    chk({30'h0, cmp_a[0], cmp_b[0]}, 32'h1);
    setc(1, 1'b1, 1'b0, 32'h0, 32'h0, 32'h0, 32'h5);
    cfg[1].cmp = '{span_mode: 1'b1, mode_a: RSCC_CMP_NONE, mode_b: RSCC_CMP_NONE,
                   val_a: 32'h0, val_b: 32'hA};
    op(1, E_PRE, 32'h5);
    chk({30'h0, cmp_a[1], cmp_b[1]}, 32'h2);
    chk({30'h0, cmp_a[0], cmp_b[0]}, 32'h1);
    cfg[1].reload = 32'hFFFF;
    op(1, E_PRE, 32'hFFFF);
    chk({30'h0, cmp_a[1], cmp_b[1]}, 32'h1);
    cfg[0].reload = 32'h3;
    op(0, E_PRE, 32'h3);
    for (int v = 0; v < 2; v++) begin
      tbl = (v == 0) ? 7'h62 : 7'h54;
      cfg[0].cmp.val_a = 32'h3 + 32'(v);
      for (int m = 0; m < 7; m++) begin
        cfg[0].cmp.mode_a = rscc_cmode_t'(m);
        @(posedge sys_clk);
        #1 chk({31'h0, cmp_a[0]}, {31'h0, tbl[m]});
      end
    end
    // 32-bit signed: full range ring, then linear step overrun
    wide32 = 1'b1;
    setc(0, 1'b1, 1'b0, 32'h0, 32'h0, 32'h0, 32'h7FFFFFFF);
    op(0, E_PRE, 32'h7FFFFFFF);
    op(0, E_UP, 32'h80000000);
    op(0, E_DN, 32'h7FFFFFFF);
    chk({30'h0, ovf[0], unf[0]}, 32'h0);
    chk(tally[1], 32'h0);
    chk({30'h0, cmp_a[1], cmp_b[1]}, 32'h0);
    setc(0, 1'b0, 1'b1, 32'h0, 32'h3E8, 32'h5, 32'h3E6);
    op(0, E_PRE, 32'h3E6);
    op(0, E_UP, 32'h3E6);
    chk({31'h0, ovf[0]}, 32'h1);
    op(0, E_DN, 32'h3E6);
    cfg[0].reload = 32'h1F4;
    op(0, E_PRE, 32'h1F4);
    chk({31'h0, ovf[0]}, 32'h0);
    op(0, E_UP, 32'h1F9);
    // 32-bit unsigned ring: bounds in order, crossed, equal; then 16-bit full range
    signed_fmt = 1'b0;
    setc(0, 1'b1, 1'b0, 32'h0, 32'h7D0, 32'h0, 32'h7CF);
    op(0, E_PRE, 32'h7CF);
    op(0, E_UP, 32'h0);
    op(0, E_DN, 32'h7CF);
    setc(0, 1'b1, 1'b0, 32'h64, 32'h32, 32'h0, 32'h64);
    op(0, E_PRE, 32'h64);
    op(0, E_DN, 32'h31);
    setc(0, 1'b1, 1'b0, 32'h0, 32'h0, 32'h5, 32'h5);
    op(0, E_PRE, 32'h5);
    op(0, E_UP | E_DN, 32'h6);
    cfg[0].add_mode = 1'b1;
    op(0, E_UP, 32'hB);
    cfg[0].add_mode = 1'b0;
    wide32 = 1'b0;
    cfg[0].reload = 32'h0;
    op(0, E_PRE, 32'h0);
    op(0, E_DN, 32'hFFFF);
    // logic control stop clears the tally
    @(posedge sys_clk);
    #1 logic_run = 1'b0;
    @(posedge sys_clk);
    #1 chk(tally[0], 32'h0);
    test_done;
  end
endmodule // testbench
`default_nettype wire
